// >>> rtl/memory_map_segment_decoder.sv
// Purpose: Program and data memory map of an 8-bit controller core
// Assumes: Requests synchronous to ref_clk, one access per cycle
// Notes: Flash array is modelled as a RAM image with an erased default;
//        page blank flags and option decodes sit in the state flop
`timescale 1ns/10ps
`default_nettype none

module memory_map_segment_decoder #(
	parameter int FLASH_BYTES = 32768
) (
	input wire logic ref_clk,
	input wire logic rstn,
	// Core program side
	input wire logic fetch,
	input wire logic interrupt_take,
	input wire logic return_exec,
	input wire logic jump_valid,
	input wire logic [14:0] jump_addr,
	// Core data side
	input wire memmap_pkg::data_req_s data_req,
	input wire logic [7:0] accumulator,
	input wire logic acc_test,
	// Flash access port for programming and in-system routines
	input wire logic flash_req,
	input wire logic flash_write,
	input wire logic flash_page_erase,
	input wire logic flash_mass_erase,
	input wire logic flash_external,
	input wire logic flash_isp_user,
	input wire logic program_mode,
	input wire logic [14:0] flash_addr,
	input wire logic [7:0] flash_wdata,
	// Outputs
	output logic [14:0] program_counter_reg,
	output logic [7:0] fetch_data,
	output logic software_trap_opcode,
	output logic [7:0] data_rdata,
	output logic bit_result,
	output logic data_unmapped,
	output logic [7:0] flash_rdata,
	output logic flash_refused,
	output var memmap_pkg::ptr_regs_s ptr_regs,
	output logic [7:0] option_config_byte,
	output logic watchdog_enable,
	output logic watchdog_output_pin,
	output logic halt_allowed,
	output logic boot_from_flash
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [14:0] pc;
		logic [7:0] fetch_data;
		logic trap;
		logic [7:0] rdata;
		logic bit_result;
		logic unmapped;
		logic [7:0] frdata;
		logic refused;
		memmap_pkg::ptr_regs_s ptrs;
		logic [7:0] option;
		logic [FLASH_BYTES/memmap_pkg::PAGE_BYTES-1:0] blank;
		logic wd_en;
		logic halt_ok;
		logic boot;
	} state_s;

	state_s cur;
	state_s next_cur;

	// Arrays sit outside the struct; they carry no reset by nature
	logic [7:0] flash_mem [FLASH_BYTES];
	logic [7:0] ram [memmap_pkg::RAM_WORDS];
	logic [7:0] regfile [12];

	// ------------------------------------------------------------
	// Data address decode
	// ------------------------------------------------------------
	logic [15:0] full_addr;
	logic ram_hit;
	logic reg_hit;
	logic ptr_hit;
	logic [9:0] ram_index;
	logic [7:0] seg_eff;
	logic [7:0] old_byte;
	logic [7:0] new_byte;

	// Segment extension on the lower half only
	always_comb begin
		seg_eff = data_req.use_stack ? 8'h00 : cur.ptrs.segment;
		if (data_req.addr[7]) begin
			full_addr = {8'h00, data_req.addr};
		end else begin
			full_addr = {seg_eff, data_req.addr};
		end
		// Register bytes F0-FF, with the pointer quartet at FC-FF
		reg_hit = data_req.addr[7:4] == memmap_pkg::REG_FILE_BASE[7:4];
		ptr_hit = reg_hit && (data_req.addr[3:2] == 2'b11);
		// Segment 0 holds 00-6F; 70-7F is empty; segments 1-7 full
		ram_hit = !data_req.addr[7] && (
			(seg_eff == 8'h00 && data_req.addr <= memmap_pkg::LOW_RAM_TOP) ||
			(seg_eff != 8'h00 && seg_eff <= memmap_pkg::MAX_RAM_SEGMENT));
		// Segment bits 2:0 pick the bank; ram_hit already refused higher segments
		ram_index = {full_addr[10:8], full_addr[6:0]};
	end

	// Current byte at the address
	always_comb begin
		old_byte = 8'h00;
		if (ptr_hit) begin
			unique case (data_req.addr[1:0])
				2'b00: old_byte = cur.ptrs.alt_ptr;
				2'b01: old_byte = cur.ptrs.stack_ptr;
				2'b10: old_byte = cur.ptrs.pri_ptr;
				2'b11: old_byte = cur.ptrs.segment;
			endcase
		end else if (reg_hit) begin
			old_byte = regfile[data_req.addr[3:0]];
		end else if (ram_hit) begin
			old_byte = ram[ram_index];
		end
		// Bit set and clear are read-modify-write on any location
		unique case (data_req.bit_op)
			memmap_pkg::BIT_SET: new_byte = old_byte | (8'h01 << data_req.bit_sel);
			memmap_pkg::BIT_CLEAR: new_byte = old_byte & ~(8'h01 << data_req.bit_sel);
			default: new_byte = data_req.wdata;
		endcase
	end

	// Any store, including the read-modify-write of a bit set or clear
	logic data_wr;
	assign data_wr = data_req.valid && (data_req.write ||
		data_req.bit_op == memmap_pkg::BIT_SET || data_req.bit_op == memmap_pkg::BIT_CLEAR);

	// ------------------------------------------------------------
	// Flash policy
	// ------------------------------------------------------------
	logic secure;
	logic fl_is_opt;
	logic fl_wr_ok;
	logic fl_read;
	logic fl_wr_go;
	logic fl_erase_go;
	logic [14-memmap_pkg::PAGE_AW:0] fl_page;
	logic [14-memmap_pkg::PAGE_AW:0] pc_page;
	logic [7:0] fl_raw;
	logic [7:0] fetch_raw;

	// Blank pages read as erased value without clearing the whole array
	always_comb begin
		secure = cur.option[memmap_pkg::OPT_SECURITY];
		fl_is_opt = flash_addr == memmap_pkg::PROG_LAST_ADDR;
		fl_page = flash_addr[14:memmap_pkg::PAGE_AW];
		pc_page = cur.pc[14:memmap_pkg::PAGE_AW];
		fl_raw = fl_is_opt ? cur.option :
			(cur.blank[fl_page] ? memmap_pkg::PROG_ERASED : flash_mem[flash_addr]);
		fetch_raw = cur.blank[pc_page] ? memmap_pkg::PROG_ERASED : flash_mem[cur.pc];
		// Security gates writes unless user in-system; option needs program mode
		fl_wr_ok = (!secure || flash_isp_user) &&
			(!fl_is_opt || program_mode);
		// Plain read: a request with no write or erase strobe
		fl_read = flash_req && !flash_write && !flash_page_erase && !flash_mass_erase;
		// Byte program of the array; the option byte lives in the state instead
		fl_wr_go = flash_req && flash_write && fl_wr_ok && !fl_is_opt;
		// Page erase obeys the same gate as a write
		fl_erase_go = flash_req && flash_page_erase && fl_wr_ok;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_cur = cur;
		next_cur.trap = 1'b0;
		next_cur.refused = 1'b0;
		// Program counter sequencing
		if (interrupt_take) begin
			next_cur.pc = memmap_pkg::PROG_VECTOR_ADDR;
		end else if (return_exec && cur.ptrs.stack_ptr == memmap_pkg::STACK_RESET) begin
			next_cur.pc = memmap_pkg::PROG_LAST_ADDR;
		end else if (jump_valid) begin
			next_cur.pc = jump_addr;
		end else if (fetch) begin
			next_cur.pc = cur.pc + 15'h0001;
		end
		if (fetch) begin
			// The last location always fetches as the trap opcode
			if (cur.pc == memmap_pkg::PROG_LAST_ADDR) begin
				next_cur.fetch_data = memmap_pkg::PROG_ERASED;
				next_cur.trap = 1'b1;
			end else begin
				next_cur.fetch_data = fetch_raw;
				next_cur.trap = fetch_raw == memmap_pkg::PROG_ERASED;
			end
		end
		// Data read, bit test and accumulator test
		if (data_req.valid) begin
			next_cur.unmapped = !(ram_hit || reg_hit || data_req.addr[7]);
			next_cur.rdata = old_byte;
			next_cur.bit_result = old_byte[data_req.bit_sel];
			if (data_wr && ptr_hit) begin
				unique case (data_req.addr[1:0])
					2'b00: next_cur.ptrs.alt_ptr = new_byte;
					2'b01: next_cur.ptrs.stack_ptr = new_byte;
					2'b10: next_cur.ptrs.pri_ptr = new_byte;
					2'b11: next_cur.ptrs.segment = new_byte;
				endcase
			end
		end
		if (acc_test) begin
			next_cur.bit_result = accumulator[data_req.bit_sel];
		end
		// External programmer and in-system flash reads
		if (fl_read) begin
			if (secure && flash_external && !fl_is_opt) begin
				next_cur.frdata = memmap_pkg::PROG_SECURE_READ;
			end else if (secure && !flash_external && !flash_isp_user && !fl_is_opt) begin
				next_cur.frdata = memmap_pkg::PROG_SECURE_READ;
				next_cur.refused = 1'b1;
			end else begin
				next_cur.frdata = fl_raw;
			end
		end
		if (flash_req && flash_mass_erase) begin
			next_cur.option = memmap_pkg::OPTION_RESET;
		end else if (flash_req && flash_write && fl_is_opt && fl_wr_ok) begin
			next_cur.option = flash_wdata & ~memmap_pkg::OPT_RESERVED_MASK;
		end else if (flash_req && (flash_write || flash_page_erase) && !fl_wr_ok) begin
			next_cur.refused = 1'b1;
		end
		// Page blank flags: mass erase blanks all, page erase one 128-byte page
		if (flash_req && flash_mass_erase) begin
			next_cur.blank = '1;
		end else if (fl_erase_go) begin
			next_cur.blank[fl_page] = 1'b1;
		end else if (fl_wr_go) begin
			next_cur.blank[fl_page] = 1'b0;
		end
		// Option decodes are registered so every output leaves a flop
		next_cur.wd_en = !next_cur.option[memmap_pkg::OPT_WATCHDOG];
		next_cur.halt_ok = !next_cur.option[memmap_pkg::OPT_HALT];
		next_cur.boot = next_cur.option[memmap_pkg::OPT_FLEX];
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			// Alternate and primary pointers start at zero; RAM keeps no reset
			cur <= '0;
			cur.pc <= memmap_pkg::PROG_RESET_ADDR;
			cur.ptrs.stack_ptr <= memmap_pkg::STACK_RESET;
			cur.ptrs.segment <= memmap_pkg::SEGMENT_RESET;
			cur.option <= memmap_pkg::OPTION_RESET;
			cur.blank <= '1;
			cur.wd_en <= !memmap_pkg::OPTION_RESET[memmap_pkg::OPT_WATCHDOG];
			cur.halt_ok <= !memmap_pkg::OPTION_RESET[memmap_pkg::OPT_HALT];
			cur.boot <= memmap_pkg::OPTION_RESET[memmap_pkg::OPT_FLEX];
		end else begin
			cur <= next_cur;
		end
	end

	// Flash byte writes; the first write into a blank page zeroes the rest of the
	// page, because the blank flag drops and stale bytes would otherwise show
	always_ff @(posedge ref_clk) begin
		if (fl_wr_go) begin
			if (cur.blank[fl_page]) begin
				for (int i = 0; i < memmap_pkg::PAGE_BYTES; i++) begin
					flash_mem[{fl_page, i[memmap_pkg::PAGE_AW-1:0]}] <= memmap_pkg::PROG_ERASED;
				end
			end
			flash_mem[flash_addr] <= flash_wdata;
		end
	end

	// RAM and general registers; writes to empty addresses are dropped
	always_ff @(posedge ref_clk) begin
		if (data_wr && ram_hit) begin
			ram[ram_index] <= new_byte;
		end
		// Pointer bytes live in the state, so the register file skips FC-FF
		if (data_wr && reg_hit && !ptr_hit) begin
			regfile[data_req.addr[3:0]] <= new_byte;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Program side
	assign program_counter_reg = cur.pc;
	assign fetch_data = cur.fetch_data;
	assign software_trap_opcode = cur.trap;

	// Data side
	assign data_rdata = cur.rdata;
	assign bit_result = cur.bit_result;
	assign data_unmapped = cur.unmapped;

	// Flash side
	assign flash_rdata = cur.frdata;
	assign flash_refused = cur.refused;

	// Architectural registers
	assign ptr_regs = cur.ptrs;
	assign option_config_byte = cur.option;

	// Option decodes from flops; both watchdog outputs share the wd_en flop
	assign watchdog_enable = cur.wd_en;
	assign watchdog_output_pin = cur.wd_en;
	assign halt_allowed = cur.halt_ok;
	assign boot_from_flash = cur.boot;
endmodule : memory_map_segment_decoder

`default_nettype wire

// >>> rtl/memmap_pkg.sv
// Purpose: Constants and carrier types for the memory map decoder
// Assumes: 8-bit core, 15-bit program space, 1 KB data RAM
// Notes: Offsets and reset values live here only
package memmap_pkg;
	// ------------------------------------------------------------
	// Program space
	// ------------------------------------------------------------
	localparam int PROG_AW = 15;
	localparam logic [14:0] PROG_RESET_ADDR = 15'h0000;
	localparam logic [14:0] PROG_VECTOR_ADDR = 15'h00FF;
	localparam logic [14:0] PROG_LAST_ADDR = 15'h7FFF;
	localparam logic [7:0] PROG_ERASED = 8'h00;
	localparam logic [7:0] PROG_SECURE_READ = 8'hFF;
	localparam logic [7:0] OPTION_RESET = 8'h00;
	localparam int PAGE_BYTES = 128;
	localparam int PAGE_AW = 7;
	// ------------------------------------------------------------
	// Option byte fields
	// ------------------------------------------------------------
	localparam int OPT_SECURITY = 5;
	localparam int OPT_WATCHDOG = 2;
	localparam int OPT_HALT = 1;
	localparam int OPT_FLEX = 0;
	localparam logic [7:0] OPT_RESERVED_MASK = 8'hD8;
	// ------------------------------------------------------------
	// Data space
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_ALT_PTR = 8'hFC;
	localparam logic [7:0] ADDR_STACK_PTR = 8'hFD;
	localparam logic [7:0] ADDR_PRI_PTR = 8'hFE;
	localparam logic [7:0] ADDR_SEGMENT = 8'hFF;
	localparam logic [7:0] REG_FILE_BASE = 8'hF0;
	localparam logic [7:0] STACK_RESET = 8'h6F;
	localparam logic [7:0] LOW_RAM_TOP = 8'h6F;
	localparam logic [7:0] SEGMENT_RESET = 8'h00;
	localparam logic [7:0] MAX_RAM_SEGMENT = 8'h07;
	localparam int RAM_WORDS = 1024;
	localparam int RAM_AW = 10;

	// Bit operation selector
	typedef enum logic [1:0] {
		BIT_NONE,
		BIT_SET,
		BIT_CLEAR,
		BIT_TEST
	} bit_op_e;

	// Data access request from the core
	typedef struct packed {
		logic valid;
		logic write;
		logic use_stack;
		logic [7:0] addr;
		logic [7:0] wdata;
		bit_op_e bit_op;
		logic [2:0] bit_sel;
	} data_req_s;

	// Pointer registers
	typedef struct packed {
		logic [7:0] alt_ptr;
		logic [7:0] stack_ptr;
		logic [7:0] pri_ptr;
		logic [7:0] segment;
	} ptr_regs_s;
endpackage : memmap_pkg

// >>> tb/memmap_checker_asserts.sv
// Purpose: Port-level assertions for the memory map decoder
// Assumes: One clock domain, rstn asynchronous active low
// Notes: Bound to every decoder instance after the module
`timescale 1ns/10ps
`default_nettype none
module memmap_checker (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic fetch,
	input wire logic interrupt_take,
	input wire logic return_exec,
	input wire logic jump_valid,
	input wire memmap_pkg::data_req_s data_req,
	input wire logic [14:0] program_counter_reg,
	input wire logic [7:0] fetch_data,
	input wire logic software_trap_opcode,
	input wire logic data_unmapped,
	input wire memmap_pkg::ptr_regs_s ptr_regs
);
	// ----------
	// Checks
	// ----------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	logic other_flow;
	// A plain step only holds when no other flow strobe competes
	assign other_flow = interrupt_take | return_exec | jump_valid;
	chk_pc_step: assert property (fetch && !other_flow |=>
		program_counter_reg == $past(program_counter_reg) + 15'h1) else $error("pc did not step");
	chk_int_vector: assert property (interrupt_take |=> program_counter_reg == 15'h00FF)
		else $error("interrupt vector wrong");
	chk_trap_fetch: assert property (fetch && program_counter_reg == 15'h7FFF |=>
		fetch_data == 8'h00 && software_trap_opcode) else $error("no trap at last address");
	chk_return_wrap: assert property (return_exec && !interrupt_take &&
		ptr_regs.stack_ptr == 8'h6F |=> program_counter_reg == 15'h7FFF) else $error("no wrap");
	chk_seg_load: assert property (data_req.valid && data_req.write && !data_req.use_stack &&
		data_req.addr == 8'hFF && data_req.bit_op == memmap_pkg::BIT_NONE |=>
		ptr_regs.segment == $past(data_req.wdata)) else $error("segment not loaded");
	chk_stack_seg: assert property (data_req.valid && data_req.use_stack && !data_req.addr[7]
		|=> $stable(ptr_regs.segment)) else $error("stack access moved segment");
	chk_hole_flag: assert property (data_req.valid && !data_req.use_stack &&
		ptr_regs.segment == 8'h00 && data_req.addr[7:4] == 4'h7 |=> data_unmapped)
		else $error("hole not flagged");
	chk_reset_start: assert property ($rose(rstn) |-> program_counter_reg == 15'h0000 &&
		ptr_regs.stack_ptr == 8'h6F) else $error("bad state after reset");
endmodule : memmap_checker
bind memory_map_segment_decoder memmap_checker chk (.ref_clk, .rstn, .fetch, .interrupt_take,
	.return_exec, .jump_valid, .data_req, .program_counter_reg, .fetch_data,
	.software_trap_opcode, .data_unmapped, .ptr_regs);
`default_nettype wire

// >>> tb/memory_map_segment_decoder_tb.sv
// Purpose: Self-checking bench for the memory map decoder
// Assumes: Results settle one cycle after a strobe is taken
// Notes: Drivers queue expectations; a monitor pops and compares
`timescale 1ns/10ps
`default_nettype none
module memory_map_segment_decoder_tb;
	logic ref_clk, rstn, fetch, interrupt_take, return_exec, jump_valid, acc_test, flash_req;
	logic flash_write, flash_page_erase, flash_mass_erase, flash_external, flash_isp_user;
	logic program_mode, software_trap_opcode, bit_result, data_unmapped, flash_refused;
	logic watchdog_enable, watchdog_output_pin, halt_allowed, boot_from_flash, seen;
	logic [14:0] jump_addr, flash_addr, program_counter_reg;
	logic [7:0] accumulator, flash_wdata, fetch_data, data_rdata, flash_rdata, option_config_byte;
	logic [7:0] seed, mg, v[8], exp_q[$];
	logic [1:0] mk, kind_q[$];
	memmap_pkg::data_req_s data_req;
	memmap_pkg::ptr_regs_s ptr_regs;
	int err_total, checks_done;
	string nm[4] = '{"data_rdata", "bit_result", "fetch_data", "flash_rdata"};
	memory_map_segment_decoder dut (.ref_clk, .rstn, .fetch, .interrupt_take, .return_exec,
		.jump_valid, .jump_addr, .data_req, .accumulator, .acc_test, .flash_req, .flash_write,
		.flash_page_erase, .flash_mass_erase, .flash_external, .flash_isp_user, .program_mode,
		.flash_addr, .flash_wdata, .program_counter_reg, .fetch_data, .software_trap_opcode,
		.data_rdata, .bit_result, .data_unmapped, .flash_rdata, .flash_refused, .ptr_regs,
		.option_config_byte, .watchdog_enable, .watchdog_output_pin, .halt_allowed,
		.boot_from_flash);
	// ----------
	// Helpers
	// ----------
	initial begin
		ref_clk = 1'h0;
		forever #4 ref_clk = ~ref_clk;
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic note(input logic [1:0] k, input logic [7:0] e);
		kind_q.push_back(k);
		exp_q.push_back(e);
	endtask : note
	// Read data doubles as the expectation, write data as the value
	task automatic dacc(input logic w, input logic st, input logic [7:0] a, input logic [7:0] d,
		input memmap_pkg::bit_op_e op, input logic [2:0] b, input logic [1:0] k);
		@(posedge ref_clk);
		data_req <= '{1'h1, w, st, a, d, op, b};
		if (!w)
			note(k, d);
		@(posedge ref_clk);
		data_req.valid <= 1'h0;
	endtask : dacc
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		dacc(1'h1, 1'h0, a, d, memmap_pkg::BIT_NONE, 3'h0, 2'h0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		dacc(1'h0, 1'h0, a, e, memmap_pkg::BIT_NONE, 3'h0, 2'h0);
	endtask : rd
	// Program flow strobes {fetch, interrupt, return, jump}; blank flash fetches 00
	task automatic go(input logic [3:0] m, input logic [14:0] e);
		@(posedge ref_clk);
		{fetch, interrupt_take, return_exec, jump_valid} <= m;
		jump_addr <= e;
		if (m[3])
			note(2'h2, 8'h00);
		@(posedge ref_clk);
		{fetch, interrupt_take, return_exec, jump_valid} <= 4'h0;
		#1 chk("program_counter_reg", {1'h0, e}, program_counter_reg);
		if (m[3])
			chk("software_trap_opcode", 16'h1, software_trap_opcode);
	endtask : go
	task automatic at(input logic [2:0] b, input logic [7:0] a);
		@(posedge ref_clk);
		accumulator <= a;
		data_req.bit_sel <= b;
		acc_test <= 1'h1;
		note(2'h1, {7'h0, a[b]});
		@(posedge ref_clk);
		acc_test <= 1'h0;
	endtask : at
	// Flash op {write, page erase, mass erase, external}, mode {isp, programming}
	task automatic fl(input logic [3:0] op, input logic [1:0] md, input logic [14:0] a,
		input logic [7:0] d, input logic r);
		@(posedge ref_clk);
		flash_req <= 1'h1;
		{flash_write, flash_page_erase, flash_mass_erase, flash_external} <= op;
		{flash_isp_user, program_mode} <= md;
		flash_addr <= a;
		flash_wdata <= d;
		if (op[3:1] == 3'h0)
			note(2'h3, d);
		@(posedge ref_clk);
		flash_req <= 1'h0;
		#1 chk("flash_refused", {15'h0, r}, flash_refused);
	endtask : fl
	task automatic stop_test;
		if (err_total == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// Monitor: a read taken at the last edge has its result settled now
	always @(posedge ref_clk) begin
		seen <= (data_req.valid && !data_req.write) || acc_test || fetch ||
			(flash_req && !flash_write && !flash_page_erase && !flash_mass_erase);
	end
	always @(negedge ref_clk) begin
		if (seen && kind_q.size() > 0) begin
			mk = kind_q.pop_front();
			mg = mk == 2'h0 ? data_rdata : mk == 2'h1 ? {7'h0, bit_result} :
				mk == 2'h2 ? fetch_data : flash_rdata;
			chk(nm[mk], {8'h0, exp_q.pop_front()}, {8'h0, mg});
		end
	end
	initial begin
		repeat (3000) @(posedge ref_clk);
		err_total++;
		stop_test();
	end
	// ----------
	// Scenarios
	// ----------
	initial begin
		{fetch, interrupt_take, return_exec, jump_valid, acc_test, flash_req, rstn} = 7'h0;
		{flash_write, flash_page_erase, flash_mass_erase, flash_external} = 4'h0;
		{flash_isp_user, program_mode} = 2'h0;
		{data_req, accumulator, jump_addr, flash_addr, flash_wdata} = '0;
		err_total = 0;
		checks_done = 0;
		seed = 8'h63;
		repeat (20) @(posedge ref_clk);
		rstn <= 1'h1;
		#1 chk("program_counter_reg", 16'h0, program_counter_reg);
		chk("stack_ptr", 16'h6F, ptr_regs.stack_ptr);
		chk("option_config_byte", 16'h0, option_config_byte);
		chk("levels", 16'hE, {watchdog_enable, watchdog_output_pin, halt_allowed,
			boot_from_flash});
		go(4'h8, 15'h0001);
		go(4'h4, 15'h00FF);
		go(4'h2, 15'h7FFF);
		go(4'h8, 15'h0000);
		go(4'h1, 15'h1234);
		for (int s = 0; s < 8; s++) begin
			seed = lfsr(seed);
			v[s] = seed;
			wr(8'hFF, 8'(s));
			wr(8'h05, seed);
		end
		for (int s = 0; s < 8; s++) begin
			wr(8'hFF, 8'(s));
			rd(8'h05, v[s]);
		end
		// Segment 8 must not alias onto segment 0
		wr(8'hFF, 8'h08);
		wr(8'h05, 8'h33);
		#1 chk("data_unmapped", 16'h1, data_unmapped);
		wr(8'hFF, 8'h00);
		wr(8'h70, 8'h44);
		#1 chk("data_unmapped", 16'h1, data_unmapped);
		rd(8'h05, v[0]);
		wr(8'hFF, 8'h03);
		wr(8'hF0, 8'hAA);
		wr(8'hFF, 8'h00);
		rd(8'hF0, 8'hAA);
		wr(8'hFC, 8'h5A);
		wr(8'hFE, 8'hA5);
		#1 chk("ptr_regs", 16'h5AA5, {ptr_regs.alt_ptr, ptr_regs.pri_ptr});
		wr(8'hFF, 8'h05);
		dacc(1'h1, 1'h1, 8'h20, 8'h5C, memmap_pkg::BIT_NONE, 3'h0, 2'h0);
		#1 chk("segment", 16'h5, ptr_regs.segment);
		wr(8'hFF, 8'h00);
		rd(8'h20, 8'h5C);
		wr(8'h40, 8'h00);
		dacc(1'h1, 1'h0, 8'h40, 8'h00, memmap_pkg::BIT_SET, 3'h3, 2'h0);
		rd(8'h40, 8'h08);
		dacc(1'h0, 1'h0, 8'h40, 8'h01, memmap_pkg::BIT_TEST, 3'h3, 2'h1);
		dacc(1'h1, 1'h0, 8'h40, 8'h00, memmap_pkg::BIT_CLEAR, 3'h3, 2'h0);
		rd(8'h40, 8'h00);
		for (int b = 0; b < 8; b++) begin
			seed = lfsr(seed);
			at(3'(b), seed);
		end
		fl(4'h8, 2'h0, 15'h007F, 8'h11, 1'h0);
		fl(4'h8, 2'h0, 15'h0080, 8'h22, 1'h0);
		fl(4'h1, 2'h0, 15'h007F, 8'h11, 1'h0);
		fl(4'h4, 2'h0, 15'h0010, 8'h00, 1'h0);
		fl(4'h1, 2'h0, 15'h007F, 8'h00, 1'h0);
		fl(4'h1, 2'h0, 15'h0080, 8'h22, 1'h0);
		fl(4'h1, 2'h0, 15'h0081, 8'h00, 1'h0);
		fl(4'h8, 2'h0, 15'h7FFF, 8'h27, 1'h1);
		fl(4'h8, 2'h1, 15'h7FFF, 8'h27, 1'h0);
		chk("option_config_byte", 16'h27, option_config_byte);
		chk("levels", 16'h1, {watchdog_enable, watchdog_output_pin, halt_allowed,
			boot_from_flash});
		fl(4'h8, 2'h0, 15'h0080, 8'h33, 1'h1);
		fl(4'h0, 2'h0, 15'h0080, 8'hFF, 1'h1);
		fl(4'h0, 2'h2, 15'h0080, 8'h22, 1'h0);
		fl(4'h1, 2'h0, 15'h0080, 8'hFF, 1'h0);
		fl(4'h1, 2'h0, 15'h7FFF, 8'h27, 1'h0);
		fl(4'h2, 2'h0, 15'h0000, 8'h00, 1'h0);
		chk("option_config_byte", 16'h0, option_config_byte);
		stop_test();
	end
endmodule : memory_map_segment_decoder_tb
`default_nettype wire
